// ---- hw/i2cber_regs.svh ----
// register offsets, field positions, status codes and timing counts of the bus recovery block
`ifndef I2CBER_REGS_SVH
`define I2CBER_REGS_SVH
`define I2CBER_ADDR_CONSET   3'h0
`define I2CBER_ADDR_CONCLR   3'h1
`define I2CBER_ADDR_STATUS   3'h2
`define I2CBER_ADDR_OWNADR   3'h3
`define I2CBER_ADDR_RATE     3'h4
`define I2CBER_ADDR_CONTROL  3'h5
`define I2CBER_ADDR_LINES    3'h6
`define I2CBER_BIT_AA        2
`define I2CBER_BIT_SI        3
`define I2CBER_BIT_STO       4
`define I2CBER_BIT_STA       5
`define I2CBER_BIT_EN        6
`define I2CBER_CTRL_MASK     8'h7C
`define I2CBER_CTRL_RST      8'h00
`define I2CBER_ST_IDLE       8'hF8
`define I2CBER_ST_BUSERR     8'h00
`define I2CBER_ST_START      8'h08
`define I2CBER_ST_RSTART     8'h10
`define I2CBER_ST_AL_MT      8'h38
`define I2CBER_ST_AL_SR      8'h68
`define I2CBER_ST_AL_GC      8'h78
`define I2CBER_ST_AL_ST      8'hB0
`define I2CBER_RATE_RST      16'h0000
`define I2CBER_HALF_DEFAULT  16'h0032
`define I2CBER_PULSES        2'h2
`endif

// ---- hw/i2cber_pkg.sv ----
// types shared by the bus recovery block
package i2cber_pkg;
  typedef enum logic [3:0] {
    I2CBER_IDLE,
    I2CBER_WAIT_FREE,
    I2CBER_START_SETUP,
    I2CBER_START_HOLD,
    I2CBER_CLK_LOW,
    I2CBER_CLK_HIGH,
    I2CBER_XFER,
    I2CBER_RS_SETUP,
    I2CBER_RS_HOLD,
    I2CBER_SLAVE
  } i2cber_state_t;
endpackage

// ---- hw/i2cber_top.sv ----
// two-wire bus error detection, recovery and forced access logic
// Overview of operation
// - status reads 0xF8 while event flag clear
// - start or stop inside frame is error
// - errors only count when master or addressed
// - error: unaddressed slave, release, flag, 0x00
// - undefined internal state reports code 0x00
// - stop plus flag clear recovers, no STOP
// - foreign repeated start first: release, no event
// - after foreign stop send start, code 0x08
// - lost arbitration codes 38, 68, 78, B0
// - start flag after loss restarts when free
// - stop with start forces access, stop cleared
// - clock held low: wait, no recovery
// - data held low: extra clocks, retry every two
// - data released: start, 0x08, continue alone
// - same recovery for forced or repeated start
`include "i2cber_regs.svh"
module i2cber_top #(
  parameter int ADDR_W = 3
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RST_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [7:0]        WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [7:0]        RDATA_O,
  input  wire logic              SCL_I,
  output logic                   SCL_O,
  output logic                   SCL_OE_N_O,
  input  wire logic              SDA_I,
  output logic                   SDA_O,
  output logic                   SDA_OE_N_O,
  input  wire logic              XFER_ACTIVE_I,
  input  wire logic              SLAVE_ADDRESSED_I,
  input  wire logic              FRAME_INSIDE_I,
  input  wire logic              RS_PENDING_I,
  input  wire logic              ARB_LOST_I,
  input  wire logic [1:0]        ARB_KIND_I,
  input  wire logic              XFER_DONE_I,
  output logic                   START_DONE_O,
  output logic                   MASTER_ROLE_O,
  output logic                   SLAVE_ROLE_O
);
  initial begin
    if (ADDR_W < 3) $error("ADDR_W must be at least 3");
  end

  logic [7:0]  control_flags_r;
  logic [7:0]  bus_status_code_r;
  logic [7:0]  own_slave_address_r;
  logic [15:0] half_period_r;
  logic [1:0]  scl_sync_r;
  logic [1:0]  sda_sync_r;
  logic        scl_d_r;
  logic        sda_d_r;
  logic        bus_busy_r;
  logic [15:0] tick_cnt_r;
  logic [1:0]  pulse_cnt_r;
  logic        scl_drive_low_r;
  logic        sda_drive_low_r;
  logic        start_done_r;
  i2cber_pkg::i2cber_state_t state_r;

  logic scl_s;
  logic sda_s;
  logic start_seen;
  logic stop_seen;
  logic tick;
  logic wr_set;
  logic wr_clr;
  logic involved;
  logic bus_err;
  logic forced;
  logic recover;
  logic gen_start_done;
  logic foreign_rs;

  // address decode of a strobed access
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [2:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  // two-stage synchronisers for the bus lines
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], SCL_I};
      sda_sync_r <= {sda_sync_r[0], SDA_I};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  // start and stop detection on synchronised lines
  assign scl_s      = scl_sync_r[1];
  assign sda_s      = sda_sync_r[1];
  assign start_seen = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_seen  = scl_s && scl_d_r && !sda_d_r && sda_s;

  // strobed writes to the set and clear ports
  assign wr_set  = WR_I && hit(ADDR_I, `I2CBER_ADDR_CONSET);
  assign wr_clr  = WR_I && hit(ADDR_I, `I2CBER_ADDR_CONCLR);
  assign involved = (state_r == i2cber_pkg::I2CBER_XFER) || (state_r == i2cber_pkg::I2CBER_SLAVE)
                    || (state_r == i2cber_pkg::I2CBER_RS_SETUP);
  assign bus_err = (start_seen || stop_seen) && FRAME_INSIDE_I && involved;
  assign forced  = control_flags_r[`I2CBER_BIT_STA] && control_flags_r[`I2CBER_BIT_STO]
                   && bus_busy_r;
  // recovery needs the error code, a stop request and a cleared flag
  assign recover = control_flags_r[`I2CBER_BIT_STO] && !control_flags_r[`I2CBER_BIT_SI]
                   && (bus_status_code_r == `I2CBER_ST_BUSERR) && !control_flags_r[`I2CBER_BIT_STA];
  // start hold over: our start is complete
  assign gen_start_done = (state_r == i2cber_pkg::I2CBER_START_HOLD) && tick;
  assign foreign_rs = (state_r == i2cber_pkg::I2CBER_RS_SETUP) && start_seen;

  // bus busy between start and stop, forced free on request
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bus_busy_r <= 1'b0;
    end else if (forced) begin
      bus_busy_r <= 1'b0;
    end else if (start_seen) begin
      bus_busy_r <= 1'b1;
    end else if (stop_seen) begin
      bus_busy_r <= 1'b0;
    end
  end

  // half bit period divider, frozen while another device stretches clock
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_cnt_r <= 16'h0000;
    end else if (tick || (state_r == i2cber_pkg::I2CBER_IDLE)) begin
      tick_cnt_r <= 16'h0000;
    end else if (!(scl_drive_low_r == 1'b0 && !scl_s && state_r == i2cber_pkg::I2CBER_CLK_HIGH)) begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end
  assign tick = (tick_cnt_r >= half_period_r);

  // control flags: set and clear ports and hardware updates
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      control_flags_r <= `I2CBER_CTRL_RST;
    end else begin
      if (wr_set) begin
        control_flags_r <= control_flags_r | (WDATA_I & `I2CBER_CTRL_MASK);
      end else if (wr_clr) begin
        control_flags_r <= control_flags_r & ~(WDATA_I & `I2CBER_CTRL_MASK);
      end
      if (recover || forced) begin
        control_flags_r[`I2CBER_BIT_STO] <= 1'b0;
      end
      if (gen_start_done) begin
        control_flags_r[`I2CBER_BIT_STA] <= 1'b0;
      end
      // foreign repeated start: set the start request so a retry follows the stop
      if (foreign_rs) begin
        control_flags_r[`I2CBER_BIT_STA] <= 1'b1;
      end
      // hardware set wins over a same-cycle clear
      if (bus_err || gen_start_done || ARB_LOST_I || XFER_DONE_I
          || (state_r > i2cber_pkg::I2CBER_SLAVE)) begin
        control_flags_r[`I2CBER_BIT_SI] <= 1'b1;
      end
    end
  end

  // status code register
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bus_status_code_r <= `I2CBER_ST_IDLE;
    end else if (bus_err || state_r > i2cber_pkg::I2CBER_SLAVE) begin
      bus_status_code_r <= `I2CBER_ST_BUSERR;
    end else if (gen_start_done) begin
      bus_status_code_r <= `I2CBER_ST_START;
    end else if (ARB_LOST_I) begin
      case (ARB_KIND_I)
        2'h0:    bus_status_code_r <= `I2CBER_ST_AL_MT;
        2'h1:    bus_status_code_r <= `I2CBER_ST_AL_SR;
        2'h2:    bus_status_code_r <= `I2CBER_ST_AL_GC;
        default: bus_status_code_r <= `I2CBER_ST_AL_ST;
      endcase
    end else if (!control_flags_r[`I2CBER_BIT_SI] && !recover) begin
      bus_status_code_r <= `I2CBER_ST_IDLE;
    end
  end

  // software-held configuration
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      own_slave_address_r <= 8'h00;
      half_period_r       <= `I2CBER_HALF_DEFAULT;
    end else if (WR_I && hit(ADDR_I, `I2CBER_ADDR_OWNADR)) begin
      own_slave_address_r <= WDATA_I;
    end else if (WR_I && hit(ADDR_I, `I2CBER_ADDR_RATE)) begin
      half_period_r <= (WDATA_I == 8'h00) ? `I2CBER_HALF_DEFAULT : {8'h00, WDATA_I};
    end
  end

  // recovery and start generation sequencer
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r         <= i2cber_pkg::I2CBER_IDLE;
      scl_drive_low_r <= 1'b0;
      sda_drive_low_r <= 1'b0;
      pulse_cnt_r     <= 2'h0;
    end else if (bus_err || recover || foreign_rs || !control_flags_r[`I2CBER_BIT_EN]) begin
      state_r         <= i2cber_pkg::I2CBER_IDLE;
      scl_drive_low_r <= 1'b0;
      sda_drive_low_r <= 1'b0;
      pulse_cnt_r     <= 2'h0;
    end else begin
      case (state_r)
        i2cber_pkg::I2CBER_IDLE: begin
          if (control_flags_r[`I2CBER_BIT_STA] && !control_flags_r[`I2CBER_BIT_SI]) begin
            state_r <= i2cber_pkg::I2CBER_WAIT_FREE;
          end else if (SLAVE_ADDRESSED_I) begin
            state_r <= i2cber_pkg::I2CBER_SLAVE;
          end
        end
        i2cber_pkg::I2CBER_WAIT_FREE: begin
          // a clock line held low by another device keeps us here
          if (!bus_busy_r && scl_s) begin
            state_r <= i2cber_pkg::I2CBER_START_SETUP;
          end
        end
        i2cber_pkg::I2CBER_START_SETUP: begin
          if (tick) begin
            if (sda_s) begin
              sda_drive_low_r <= 1'b1;
              pulse_cnt_r     <= 2'h0;
              state_r         <= i2cber_pkg::I2CBER_START_HOLD;
            end else begin
              scl_drive_low_r <= 1'b1;
              state_r         <= i2cber_pkg::I2CBER_CLK_LOW;
            end
          end
        end
        i2cber_pkg::I2CBER_CLK_LOW: begin
          if (tick) begin
            scl_drive_low_r <= 1'b0;
            pulse_cnt_r     <= pulse_cnt_r + 2'h1;
            state_r         <= i2cber_pkg::I2CBER_CLK_HIGH;
          end
        end
        i2cber_pkg::I2CBER_CLK_HIGH: begin
          if (tick) begin
            // two extra pulses done: try the start again
            if (pulse_cnt_r == `I2CBER_PULSES) begin
              pulse_cnt_r <= 2'h0;
              state_r     <= i2cber_pkg::I2CBER_START_SETUP;
            end else begin
              scl_drive_low_r <= 1'b1;
              state_r         <= i2cber_pkg::I2CBER_CLK_LOW;
            end
          end
        end
        i2cber_pkg::I2CBER_START_HOLD: begin
          if (tick) begin
            state_r <= i2cber_pkg::I2CBER_XFER;
          end
        end
        i2cber_pkg::I2CBER_XFER: begin
          // start held long enough: the transfer engine owns data now
          sda_drive_low_r <= 1'b0;
          if (RS_PENDING_I) begin
            state_r <= i2cber_pkg::I2CBER_RS_SETUP;
          end else if (ARB_LOST_I || XFER_DONE_I) begin
            state_r <= i2cber_pkg::I2CBER_IDLE;
          end
        end
        i2cber_pkg::I2CBER_RS_SETUP: begin
          if (tick) begin
            state_r <= i2cber_pkg::I2CBER_START_SETUP;
          end
        end
        i2cber_pkg::I2CBER_SLAVE: begin
          if (!SLAVE_ADDRESSED_I) begin
            state_r <= i2cber_pkg::I2CBER_IDLE;
          end
        end
        default: begin
          state_r <= i2cber_pkg::I2CBER_IDLE;
        end
      endcase
    end
  end

  // one-cycle start done pulse
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      start_done_r <= 1'b0;
    end else begin
      start_done_r <= gen_start_done;
    end
  end

  // register read port, data one cycle after strobe
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      if (hit(ADDR_I, `I2CBER_ADDR_CONSET) || hit(ADDR_I, `I2CBER_ADDR_CONTROL)) begin
        RDATA_O <= control_flags_r;
      end else if (hit(ADDR_I, `I2CBER_ADDR_STATUS)) begin
        RDATA_O <= bus_status_code_r;
      end else if (hit(ADDR_I, `I2CBER_ADDR_OWNADR)) begin
        RDATA_O <= own_slave_address_r;
      end else if (hit(ADDR_I, `I2CBER_ADDR_RATE)) begin
        RDATA_O <= half_period_r[7:0];
      end else if (hit(ADDR_I, `I2CBER_ADDR_LINES)) begin
        RDATA_O <= {5'h00, bus_busy_r, sda_s, scl_s};
      end else begin
        RDATA_O <= 8'h00;
      end
    end
  end

  // open-drain outputs: enable low while pulling the line low
  assign SCL_O         = 1'b0;
  assign SDA_O         = 1'b0;
  assign SCL_OE_N_O    = !scl_drive_low_r;
  assign SDA_OE_N_O    = !sda_drive_low_r;
  assign START_DONE_O  = start_done_r;
  assign MASTER_ROLE_O = (state_r == i2cber_pkg::I2CBER_XFER)
                         || (state_r == i2cber_pkg::I2CBER_RS_SETUP);
  assign SLAVE_ROLE_O  = (state_r == i2cber_pkg::I2CBER_SLAVE);
endmodule

// ---- tb/i2cber_top_assertions.sv ----
// port checker of the bus recovery block
`include "i2cber_regs.svh"
module i2cber_chk #(
  parameter int ADDR_W = 3
) (
  input wire logic              SYS_CLK_I,
  input wire logic              RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [7:0]        WDATA_I,
  input wire logic              WR_I,
  input wire logic              RD_I,
  input wire logic [7:0]        RDATA_O,
  input wire logic              SCL_I,
  input wire logic              SCL_OE_N_O,
  input wire logic              SDA_I,
  input wire logic              SDA_OE_N_O,
  input wire logic              FRAME_INSIDE_I,
  input wire logic              MASTER_ROLE_O,
  input wire logic              SLAVE_ROLE_O,
  input wire logic              START_DONE_O
);
  logic err_ev, set_w, clr_w, rctl, rel;
  // helper terms
  assign err_ev = FRAME_INSIDE_I && (MASTER_ROLE_O || SLAVE_ROLE_O) && SCL_I;
  assign set_w  = WR_I && ADDR_I == `I2CBER_ADDR_CONSET;
  assign clr_w  = WR_I && ADDR_I == `I2CBER_ADDR_CONCLR;
  assign rctl   = RD_I && ADDR_I == `I2CBER_ADDR_CONTROL;
  assign rel    = SDA_OE_N_O && SCL_OE_N_O;
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  // start strobe and start shape
  a_start_single: assert property (START_DONE_O |=> !START_DONE_O)
    else $error("start done too long");
  a_start_free: assert property ($fell(SDA_OE_N_O) |-> $past(SDA_I))
    else $error("start on low data line");
  a_start_clk_high: assert property ($fell(SDA_OE_N_O) |-> SCL_OE_N_O && SCL_I)
    else $error("start with clock low");
  a_start_finish: assert property ($fell(SDA_OE_N_O) |-> ##[1:300] START_DONE_O)
    else $error("start not finished");
  // misplaced condition while involved
  a_error_release: assert property (err_ev && $fell(SDA_I) |-> ##[1:4] rel && !MASTER_ROLE_O)
    else $error("lines kept after bus error");
  // never pull a clock that another holds
  a_scl_wait: assert property ((!SCL_I && SCL_OE_N_O) [*4] |=> SCL_OE_N_O)
    else $error("clock pulled while held");
  // set and clear ports
  a_set_bits: assert property ((set_w ##1 rctl) |=>
    (RDATA_O & $past(WDATA_I, 2) & 8'h64) == ($past(WDATA_I, 2) & 8'h64))
    else $error("set bit missing");
  a_clear_bits: assert property ((clr_w ##1 rctl) |=>
    (RDATA_O & $past(WDATA_I, 2) & 8'h74) == 8'h00)
    else $error("cleared bit still set");
  c_start: cover property (START_DONE_O);
  c_extra_clk: cover property ($fell(SCL_OE_N_O) && !SDA_I);
  c_error: cover property (err_ev && $fell(SDA_I));
endmodule
bind i2cber_top i2cber_chk #(.ADDR_W(ADDR_W)) i2cber_chk_inst (.*);

// ---- tb/i2cber_bus_dev.sv ----
// second device on the two-wire bus, 400 ns link clock
module i2cber_bus_dev (
  output logic scl_low_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 200;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // data falls with clock high
  task automatic fstart();
    sda_low_o = 1'b1;
    #HALF;
    scl_low_o = 1'b1;
    #HALF;
  endtask
  // data rises with clock high, lines end released
  task automatic fstop();
    scl_low_o = 1'b1;
    sda_low_o = 1'b1;
    #HALF;
    scl_low_o = 1'b0;
    #HALF;
    sda_low_o = 1'b0;
    #HALF;
  endtask
  // data stuck low with no start seen
  task automatic stick();
    scl_low_o = 1'b1;
    #HALF;
    sda_low_o = 1'b1;
    #HALF;
    scl_low_o = 1'b0;
  endtask
  // let go with no stop
  task automatic rel();
    sda_low_o = 1'b0;
    #HALF;
    scl_low_o = 1'b0;
  endtask
endmodule

// ---- tb/i2cber_top_tb.sv ----
// self-checking bench of the bus recovery block
`include "i2cber_regs.svh"
module i2cber_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] SET = `I2CBER_ADDR_CONSET;
  localparam logic [2:0] CLR = `I2CBER_ADDR_CONCLR;
  localparam logic [2:0] STS = `I2CBER_ADDR_STATUS;
  localparam logic [2:0] CTL = `I2CBER_ADDR_CONTROL;
  localparam logic [2:0] NUL = 3'h7;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, frm = 1'b0, slave_role = 1'b0, arb = 1'b0;
  logic       rsp = 1'b0, mrole, srole;
  logic [2:0] addr = 3'h0;
  logic [1:0] kind = 2'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic       scl, sda, scl_oe_n, sda_oe_n, scl_o, sda_o, sdone, dscl, dsda;
  int         errors = 0, checks_done = 0, cyc = 0, npul = 0, at_start = 0;
  logic [7:0] codes [4] = '{8'h38, 8'h68, 8'h78, 8'hB0};
  // wired bus levels with pull-ups
  assign scl = ~dscl & (scl_oe_n | scl_o);
  assign sda = ~dsda & (sda_oe_n | sda_o);
  i2cber_top i2cber_top_inst (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_N_O(scl_oe_n),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n), .XFER_ACTIVE_I(1'b0),
    .SLAVE_ADDRESSED_I(slave_role), .FRAME_INSIDE_I(frm), .RS_PENDING_I(rsp), .ARB_LOST_I(arb),
    .ARB_KIND_I(kind), .XFER_DONE_I(1'b0), .START_DONE_O(sdone), .MASTER_ROLE_O(mrole),
    .SLAVE_ROLE_O(srole));
  i2cber_bus_dev i2cber_bus_dev_inst (.scl_low_o(dscl), .sda_low_o(dsda));
  initial forever #25 clk = ~clk;
  // clock pulses and the pulse count at our start
  always @(negedge scl_oe_n) npul++;
  always @(negedge sda_oe_n) at_start = npul;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // write, then read back to back
  task automatic op(input logic [2:0] a, input logic [7:0] d, input logic [2:0] ra,
                    input logic [7:0] exp, input string nm);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    addr <= ra;
    wr   <= 1'b0;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask
  task automatic wdone();
    for (int n = 0; n < 3000 && sdone !== 1'b1; n++) @(negedge clk);
    chk("start done", {7'h00, sdone}, 8'h01);
  endtask
  task automatic rst_dut();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    npul = 0;
    op(SET, 8'h44, CTL, 8'h44, "enable");
  endtask
  initial begin
    rst_dut();
    op(CLR, 8'h04, CTL, 8'h40, "ack clear");
    op(NUL, 8'hFF, NUL, 8'h00, "unmapped");
    op(3'h3, 8'h51, STS, 8'hF8, "idle");
    op(SET, 8'h04, CTL, 8'h44, "ack set");
    // uninvolved: misplaced conditions ignored
    frm <= 1'b1;
    i2cber_bus_dev_inst.fstart();
    i2cber_bus_dev_inst.fstop();
    frm <= 1'b0;
    op(NUL, 8'h00, STS, 8'hF8, "ignored");
    // addressed slave hit by a misplaced start
    slave_role <= 1'b1;
    frm <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("slave role", {7'h00, srole}, 8'h01);
    i2cber_bus_dev_inst.fstart();
    op(NUL, 8'h00, STS, 8'h00, "bus error");
    chk("released", {6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    slave_role <= 1'b0;
    frm <= 1'b0;
    i2cber_bus_dev_inst.fstop();
    op(SET, 8'h14, CTL, 8'h5C, "stop set");
    op(CLR, 8'h08, NUL, 8'h00, "flag clr");
    op(NUL, 8'h00, CTL, 8'h44, "recovered");
    op(NUL, 8'h00, STS, 8'hF8, "rec idle");
    chk("no stop", {6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    // start, then every lost-arbitration kind with retry
    op(SET, 8'h20, CTL, 8'h64, "start req");
    wdone();
    for (int k = 0; k < 4; k++) begin
      op(CLR, 8'h08, CTL, 8'h44, "flag clr");
      @(posedge clk);
      kind <= k[1:0];
      arb  <= 1'b1;
      @(posedge clk);
      arb <= 1'b0;
      op(SET, 8'h20, STS, codes[k], "arb lost");
      op(CLR, 8'h08, CTL, 8'h64, "retry");
      i2cber_bus_dev_inst.fstop();
      wdone();
      op(NUL, 8'h00, STS, 8'h08, "restart");
    end
    // data line stuck low
    rst_dut();
    i2cber_bus_dev_inst.stick();
    op(SET, 8'h20, CTL, 8'h64, "start req");
    for (int n = 0; n < 3000 && npul < 3; n++) @(negedge clk);
    i2cber_bus_dev_inst.rel();
    wdone();
    chk("extra clocks", at_start[7:0], 8'h04);
    op(NUL, 8'h00, STS, 8'h08, "unstuck");
    // hung busy bus, forced access
    rst_dut();
    i2cber_bus_dev_inst.fstart();
    i2cber_bus_dev_inst.rel();
    op(SET, 8'h20, STS, 8'hF8, "busy wait");
    op(SET, 8'h10, NUL, 8'h00, "forced");
    wdone();
    op(NUL, 8'h00, CTL, 8'h4C, "stop cleared");
    chk("master role", {7'h00, mrole}, 8'h01);
    // foreign repeated start while ours is pending, retry after its stop
    op(CLR, 8'h08, CTL, 8'h44, "flag clr");
    @(posedge clk);
    rsp <= 1'b1;
    @(posedge clk);
    rsp <= 1'b0;
    @(posedge clk);
    i2cber_bus_dev_inst.fstart();
    op(NUL, 8'h00, CTL, 8'h64, "no event");
    chk("rs released", {6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    i2cber_bus_dev_inst.fstop();
    wdone();
    op(NUL, 8'h00, STS, 8'h08, "rs retry");
    test_done();
  end
endmodule
